//--- pkg/fallback_serial_consts.svh
`ifndef FALLBACK_SERIAL_CONSTS_SVH
`define FALLBACK_SERIAL_CONSTS_SVH

// clock and timing
`define CLK_HZ 40000000
`define CLK_PERIOD_NS 25
`define LINK_RST_TIME_NS 10000
`define RST_CYCLES ((`LINK_RST_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// register byte offsets
`define SETUP_OFF 8'h00
`define STATUS_OFF 8'h04

// setup word fields
`define SETUP_BAUD_LSB 0
`define SETUP_BAUD_MSB 3
`define SETUP_PAR_LSB 4
`define SETUP_PAR_MSB 5
`define SETUP_ADDR_LSB 8
`define SETUP_ADDR_MSB 15

// status word fields
`define STAT_FALLBACK_BIT 0
`define STAT_INRST_BIT 1
`define STAT_BAUD_LSB 8
`define STAT_BAUD_MSB 11
`define STAT_PAR_LSB 12
`define STAT_PAR_MSB 13
`define STAT_ADDR_LSB 16
`define STAT_ADDR_MSB 23

// baud code table
`define BAUD_C0 1200
`define BAUD_C1 2400
`define BAUD_C2 4800
`define BAUD_C3 9600
`define BAUD_C4 19200
`define BAUD_C5 38400
`define BAUD_C6 57600
`define BAUD_C7 115200

// fixed fallback link settings
`define FALLBACK_BAUD `BAUD_C3
`define FALLBACK_BAUD_CODE 4'h3
`define FALLBACK_ADDR 8'h01

// reset values of the stored setup
`define SETUP_RST_BAUD 4'h3
`define SETUP_RST_PAR 2'h0
`define SETUP_RST_ADDR 8'h01

`endif

//--- pkg/fallback_serial_pkg.sv
package fallback_serial_pkg;

    // parity encoding of the setup word
    typedef enum logic [1:0] {PAR_NONE, PAR_EVEN, PAR_ODD} parity_t;

    // ahb transfer kinds
    typedef enum logic [1:0] {TR_IDLE, TR_BUSY, TR_NONSEQ, TR_SEQ} htrans_t;

endpackage

//--- verilog/fallback_serial_config.sv
// Our own choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "fallback_serial_consts.svh"

module fallback_serial_config
    import fallback_serial_pkg::*;
#(
    parameter int CLK_HZ = `CLK_HZ,
    parameter int RST_CYCLES = `RST_CYCLES
)
(
    input wire logic hclk, // bus clock, 40 MHz
    input wire logic hresetn, // async reset, active low
    input wire logic ce, // clock enable, freezes state when low
    input wire logic hsel, // slave select
    input wire logic [7:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer kind
    input wire logic hwrite, // write transfer
    input wire logic [2:0] hsize, // word transfers only
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready
    output logic [31:0] hrdata, // read data
    output logic hreadyout, // slave ready
    output logic hresp, // always okay
    input wire logic override_n, // fallback override, active low
    input wire logic [15:0] nv_rd_data, // setup word held in nv store
    output logic nv_wr, // pulse: persist nv_wr_data
    output logic [15:0] nv_wr_data, // setup word to persist
    input wire logic frame_valid, // pulse: frame address byte valid
    input wire logic [7:0] frame_addr, // slave address byte of frame
    output logic addr_match, // pulse: frame is for this slave
    output logic [15:0] baud_div, // clocks per bit for the uart
    output logic [1:0] parity_mode, // parity for the uart
    output logic [7:0] slave_addr, // effective slave address
    output logic link_rst_n, // internal link reset, active low
    output logic fallback_active // fallback mode in force
);

    // baud code to clocks per bit
    function automatic logic [15:0] div_of(input logic [3:0] code);
        int baud;
        baud = `FALLBACK_BAUD;
        unique case (code)
            4'h0: baud = `BAUD_C0;
            4'h1: baud = `BAUD_C1;
            4'h2: baud = `BAUD_C2;
            4'h3: baud = `BAUD_C3;
            4'h4: baud = `BAUD_C4;
            4'h5: baud = `BAUD_C5;
            4'h6: baud = `BAUD_C6;
            4'h7: baud = `BAUD_C7;
            default: baud = `FALLBACK_BAUD;
        endcase
        return 16'(CLK_HZ / baud);
    endfunction

    // elaboration checks
    generate
        if (RST_CYCLES < 2 || RST_CYCLES > 65535 || CLK_HZ / `BAUD_C0 > 65535)
        begin : g_bad_param
            $error("fallback_serial_config: parameter out of range");
        end
    endgenerate

    logic fallback;
    logic fallback_d;
    logic [15:0] rst_cnt;
    logic load_pend;
    logic [3:0] stored_baud;
    logic [1:0] stored_par;
    logic [7:0] stored_addr;
    logic [3:0] eff_code;
    logic pend;
    logic pend_write;
    logic [7:0] pend_addr;
    logic release_evt;
    logic use_fixed;
    logic reload;
    logic wr_commit;
    logic [3:0] sel_code;
    logic [1:0] sel_par;
    logic [7:0] sel_addr;
    logic [31:0] rd_word;

    // mode selection and event decode
    assign release_evt = fallback_d && !fallback;
    // release cycle keeps the fixed values, and the internal reset holds them until it ends
    assign use_fixed = fallback || release_evt || (rst_cnt > 16'h1);
    assign reload = load_pend || (rst_cnt == 16'h2);
    assign wr_commit = pend && pend_write && (pend_addr == `SETUP_OFF);
    assign sel_code = use_fixed ? `FALLBACK_BAUD_CODE : stored_baud;
    assign sel_par = use_fixed ? 2'(PAR_NONE) : stored_par;
    assign sel_addr = use_fixed ? `FALLBACK_ADDR : stored_addr;

    // override pin sampling and release edge
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            fallback <= 1'b0;
            fallback_d <= 1'b0;
        end
        else if (ce)
        begin
            fallback <= ~override_n;
            fallback_d <= fallback;
        end
    end

    // internal reset after release of the override
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rst_cnt <= 16'h0;
            link_rst_n <= 1'b1;
        end
        else if (ce)
        begin
            if (release_evt)
                rst_cnt <= 16'(RST_CYCLES);
            else if (rst_cnt != 16'h0)
                rst_cnt <= rst_cnt - 16'h1;
            link_rst_n <= !(release_evt || (rst_cnt > 16'h1));
        end
    end

    // stored setup: loaded from nv store, changed only by bus writes
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            load_pend <= 1'b1;
            stored_baud <= `SETUP_RST_BAUD;
            stored_par <= `SETUP_RST_PAR;
            stored_addr <= `SETUP_RST_ADDR;
        end
        else if (ce)
        begin
            load_pend <= 1'b0;
            if (wr_commit)
            begin
                stored_baud <= hwdata[`SETUP_BAUD_MSB:`SETUP_BAUD_LSB];
                stored_par <= hwdata[`SETUP_PAR_MSB:`SETUP_PAR_LSB];
                stored_addr <= hwdata[`SETUP_ADDR_MSB:`SETUP_ADDR_LSB];
            end
            else if (reload)
            begin
                stored_baud <= nv_rd_data[`SETUP_BAUD_MSB:`SETUP_BAUD_LSB];
                stored_par <= nv_rd_data[`SETUP_PAR_MSB:`SETUP_PAR_LSB];
                stored_addr <= nv_rd_data[`SETUP_ADDR_MSB:`SETUP_ADDR_LSB];
            end
        end
    end

    // persist every setup write to the nv store
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            nv_wr <= 1'b0;
            nv_wr_data <= 16'h0;
        end
        else if (ce)
        begin
            nv_wr <= wr_commit;
            if (wr_commit)
                nv_wr_data <= hwdata[15:0];
        end
    end

    // effective link settings for the uart
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            eff_code <= `FALLBACK_BAUD_CODE;
            baud_div <= 16'(CLK_HZ / `FALLBACK_BAUD);
            parity_mode <= 2'(PAR_NONE);
            slave_addr <= `FALLBACK_ADDR;
            fallback_active <= 1'b0;
        end
        else if (ce)
        begin
            eff_code <= sel_code;
            baud_div <= div_of(sel_code);
            parity_mode <= sel_par;
            slave_addr <= sel_addr;
            fallback_active <= fallback;
        end
    end

    // slave address field of each rtu frame
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            addr_match <= 1'b0;
        else if (ce)
            addr_match <= frame_valid && (frame_addr == sel_addr);
    end

    // read mux
    always_comb
    begin
        rd_word = 32'h0;
        if (pend_addr == `SETUP_OFF)
        begin
            rd_word[`SETUP_BAUD_MSB:`SETUP_BAUD_LSB] = stored_baud;
            rd_word[`SETUP_PAR_MSB:`SETUP_PAR_LSB] = stored_par;
            rd_word[`SETUP_ADDR_MSB:`SETUP_ADDR_LSB] = stored_addr;
        end
        else if (pend_addr == `STATUS_OFF)
        begin
            rd_word[`STAT_FALLBACK_BIT] = fallback_active;
            rd_word[`STAT_INRST_BIT] = !link_rst_n;
            rd_word[`STAT_BAUD_MSB:`STAT_BAUD_LSB] = eff_code;
            rd_word[`STAT_PAR_MSB:`STAT_PAR_LSB] = parity_mode;
            rd_word[`STAT_ADDR_MSB:`STAT_ADDR_LSB] = slave_addr;
        end
    end

    // ahb slave: one wait state for every transfer
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pend <= 1'b0;
            pend_write <= 1'b0;
            pend_addr <= 8'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h0;
        end
        else if (ce)
        begin
            hresp <= 1'b0;
            if (pend)
            begin
                pend <= 1'b0;
                hreadyout <= 1'b1;
                if (!pend_write)
                    hrdata <= rd_word;
            end
            else if (hsel && hready && htrans[1])
            begin
                pend <= 1'b1;
                pend_write <= hwrite;
                pend_addr <= {haddr[7:2], 2'b00};
                hreadyout <= 1'b0;
            end
        end
    end

    AST_FALLBACK_LINK: assert property (@(posedge hclk) disable iff (!hresetn)
        (ce && fallback) |=> (baud_div == 16'(CLK_HZ / `FALLBACK_BAUD)
            && parity_mode == 2'(PAR_NONE)))
        else $error("fallback link not 9600 no parity");

    AST_FALLBACK_ADDR: assert property (@(posedge hclk) disable iff (!hresetn)
        (ce && fallback && frame_valid) |=> (addr_match == ($past(frame_addr) == `FALLBACK_ADDR)))
        else $error("fallback address filter wrong");

    AST_STORE_KEEP: assert property (@(posedge hclk) disable iff (!hresetn)
        (ce && $rose(fallback) && !wr_commit && !reload)
            |=> ($stable(stored_baud) && $stable(stored_par) && $stable(stored_addr)))
        else $error("stored setup changed on fallback entry");

    AST_SETUP_READ: assert property (@(posedge hclk) disable iff (!hresetn)
        (ce && pend && !pend_write && pend_addr == `SETUP_OFF && !reload)
            |=> (hreadyout && hrdata[15:0] == {stored_addr, 2'b00, stored_par, stored_baud}))
        else $error("setup read data wrong");

    AST_FALLBACK_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
        (ce && wr_commit && fallback) |=> (stored_baud == $past(hwdata[3:0])
            && baud_div == 16'(CLK_HZ / `FALLBACK_BAUD)))
        else $error("fallback write lost or link changed");

    AST_RELEASE_RESET: assert property (@(posedge hclk) disable iff (!hresetn)
        (ce && release_evt) |=> (!link_rst_n && rst_cnt == 16'(RST_CYCLES)
            && baud_div == 16'(CLK_HZ / `FALLBACK_BAUD)))
        else $error("no internal reset on release");

    AST_RESET_END: assert property (@(posedge hclk) disable iff (!hresetn)
        (ce && rst_cnt == 16'h1 && !fallback && !release_evt)
            |=> (link_rst_n && baud_div == div_of(stored_baud) && parity_mode == stored_par))
        else $error("stored setup not applied after internal reset");

    AST_NV_PERSIST: assert property (@(posedge hclk) disable iff (!hresetn)
        (ce && wr_commit) |=> (nv_wr && nv_wr_data == $past(hwdata[15:0])))
        else $error("setup write not persisted");

    AST_NORMAL_ADDR: assert property (@(posedge hclk) disable iff (!hresetn)
        (ce && !use_fixed && frame_valid && frame_addr == stored_addr) |=> addr_match)
        else $error("stored address not answered");

    COV_FALLBACK_WRITE: cover property (@(posedge hclk) disable iff (!hresetn)
        ce && wr_commit && fallback);
    COV_RELEASE: cover property (@(posedge hclk) disable iff (!hresetn)
        ce && release_evt);
    COV_NORMAL_MATCH: cover property (@(posedge hclk) disable iff (!hresetn)
        ce && !use_fixed && addr_match);

endmodule // fallback_serial_config

//--- tb/fallback_serial_partner.sv
`timescale 1ns/1ps
// far side: nv setup store and the link master's frame address stream
module fallback_serial_partner
(
    input wire logic hclk, // bus clock
    input wire logic nv_wr, // persist strobe from the block
    input wire logic [15:0] nv_wr_data, // word to persist
    output logic [15:0] nv_rd_data, // stored setup word
    output logic frame_valid, // address byte strobe
    output logic [7:0] frame_addr, // address byte
    input wire logic addr_match // answer of the block
);
    // nonvolatile store, survives every reset of the block
    logic [15:0] store = 16'h2214;
    always_ff @(posedge hclk)
    begin
        if (nv_wr)
        begin
            store <= nv_wr_data;
        end
    end
    assign nv_rd_data = store;
    initial
    begin
        frame_valid = 1'b0;
        frame_addr = 8'h00;
    end
    // one address byte; line shows inverse once the byte is gone
    task automatic send(input logic [7:0] a, output logic m);
        @(posedge hclk);
        frame_valid <= 1'b1;
        frame_addr <= a;
        @(posedge hclk);
        frame_valid <= 1'b0;
        frame_addr <= ~a;
        @(negedge hclk);
        m = addr_match;
    endtask
endmodule // fallback_serial_partner

//--- tb/fallback_serial_config_tb_top.sv
`timescale 1ns/1ps
`include "fallback_serial_consts.svh"
module fallback_serial_config_tb_top;
    import fallback_serial_pkg::*;
    localparam int RSTC = 4;
    logic hclk, hresetn, ce, hsel, hwrite, override_n;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, rd;
    logic hreadyout, hresp, nv_wr, frame_valid, addr_match, link_rst_n, fallback_active, m;
    logic [15:0] nv_rd_data, nv_wr_data, baud_div;
    logic [1:0] parity_mode;
    logic [7:0] slave_addr, frame_addr;
    int errors = 0;
    int checks_done = 0;
    int n;
    fallback_serial_config #(.RST_CYCLES(RSTC)) i_fallback_serial_config (.hclk(hclk),
        .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .override_n(override_n),
        .nv_rd_data(nv_rd_data), .nv_wr(nv_wr), .nv_wr_data(nv_wr_data),
        .frame_valid(frame_valid), .frame_addr(frame_addr), .addr_match(addr_match),
        .baud_div(baud_div), .parity_mode(parity_mode), .slave_addr(slave_addr),
        .link_rst_n(link_rst_n), .fallback_active(fallback_active));
    fallback_serial_partner i_fallback_serial_partner (.hclk(hclk), .nv_wr(nv_wr),
        .nv_wr_data(nv_wr_data), .nv_rd_data(nv_rd_data), .frame_valid(frame_valid),
        .frame_addr(frame_addr), .addr_match(addr_match));
    // bus clock, 25 ns
    initial
    begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    // one ahb-lite single word transfer, waits on hready each phase
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        @(negedge hclk);
        while (hreadyout !== 1'b1) @(negedge hclk);
        @(posedge hclk);
        htrans <= 2'b00;
        hwdata <= wd;
        @(negedge hclk);
        while (hreadyout !== 1'b1) @(negedge hclk);
        r = hrdata;
        chk(hresp, 1'b0, "hresp");
        @(posedge hclk);
    endtask
    // effective link settings at the ports
    task automatic link(input logic [15:0] div, input logic [1:0] p, input logic [7:0] sa);
        @(negedge hclk);
        chk(baud_div, div, "baud_div");
        chk(parity_mode, p, "parity");
        chk(slave_addr, sa, "slave_addr");
    endtask
    task automatic complete_run;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // watchdog
    initial
    begin
        #(25 * 5000);
        errors++;
        $display("BAD %0t watchdog expired", $time);
        complete_run();
    end
    initial
    begin
        hresetn = 1'b0;
        ce = 1'b1;
        hsel = 1'b0;
        haddr = 8'h00;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        override_n = 1'b1;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (4) @(posedge hclk);
        // normal mode: stored baud code 4, even parity, address 0x22
        link(`CLK_HZ / `BAUD_C4, 2'h1, 8'h22);
        i_fallback_serial_partner.send(8'h22, m);
        chk(m, 1'b1, "match stored");
        i_fallback_serial_partner.send(8'h01, m);
        chk(m, 1'b0, "foreign addr");
        ahb(1'b0, `STATUS_OFF, 32'h0, rd);
        chk(rd, 32'h00221400, "status normal");
        $display("test normal done");
        // fallback: fixed 9600 8n1 at 0x01, store kept on entry, then rewritten by a bus setup write
        override_n <= 1'b0;
        repeat (4) @(posedge hclk);
        chk(fallback_active, 1'b1, "fallback flag");
        link(`CLK_HZ / `FALLBACK_BAUD, 2'h0, 8'h01);
        chk(nv_rd_data, 16'h2214, "store kept");
        i_fallback_serial_partner.send(8'h01, m);
        chk(m, 1'b1, "match 0x01");
        i_fallback_serial_partner.send(8'h22, m);
        chk(m, 1'b0, "stored addr ignored");
        ahb(1'b0, `SETUP_OFF, 32'h0, rd);
        chk(rd, 32'h00002214, "setup readback");
        ahb(1'b1, `SETUP_OFF, 32'h00003327, rd);
        ahb(1'b0, `SETUP_OFF, 32'h0, rd);
        chk(rd, 32'h00003327, "setup written");
        chk(nv_rd_data, 16'h3327, "persisted");
        link(`CLK_HZ / `FALLBACK_BAUD, 2'h0, 8'h01);
        $display("test fallback done");
        // release: internal reset, then stored 115200 odd at 0x33
        @(posedge hclk);
        override_n <= 1'b1;
        n = 0;
        repeat (20)
        begin
            @(negedge hclk);
            if (link_rst_n === 1'b0)
                n++;
        end
        chk(n, RSTC, "internal reset length");
        link(`CLK_HZ / `BAUD_C7, 2'h2, 8'h33);
        chk(fallback_active, 1'b0, "fallback off");
        i_fallback_serial_partner.send(8'h33, m);
        chk(m, 1'b1, "match new addr");
        $display("test release done");
        // unmapped place reads zero and ignores writes
        ahb(1'b1, 8'h08, 32'hffffffff, rd);
        ahb(1'b0, 8'h08, 32'h0, rd);
        chk(rd, 32'h0, "unmapped");
        ahb(1'b0, `SETUP_OFF, 32'h0, rd);
        chk(rd, 32'h00003327, "setup intact");
        $display("test unmapped done");
        // clock enable low freezes the block: override not taken
        @(posedge hclk);
        ce <= 1'b0;
        override_n <= 1'b0;
        repeat (4) @(posedge hclk);
        link(`CLK_HZ / `BAUD_C7, 2'h2, 8'h33);
        chk(fallback_active, 1'b0, "frozen by ce");
        @(posedge hclk);
        override_n <= 1'b1;
        ce <= 1'b1;
        $display("test clock enable done");
        // reset in mid-run: stored setup comes back from the nv store
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (3) @(posedge hclk);
        link(`CLK_HZ / `BAUD_C7, 2'h2, 8'h33);
        ahb(1'b0, `SETUP_OFF, 32'h0, rd);
        chk(rd, 32'h00003327, "setup after reset");
        $display("test reset done");
        complete_run();
    end
endmodule // fallback_serial_config_tb_top
